// >>> common/fcrs_pkg.sv
// package: register map, command codes, field positions and timing for the flash sequencer
package fcrs_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_COMMAND = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;

    // control register fields
    localparam int CTL_SEL_BIT = 0;
    localparam int CTL_BUSY_BIT = 1;
    localparam int CTL_MON_BIT = 2;
    localparam int CTL_AREA_LO = 4;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WR_MASK = 8'h31;

    // command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PVERIFY = 8'hC0;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_EVERIFY = 8'hA0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] WDT_FROZEN = 16'hFFFF;

    // flash geometry: 16-bit address, four areas by the top two address bits
    localparam int FADDR_W = 16;
    localparam int AREA_HI = 15;

    // operation times
    localparam int CLK_MHZ = 125;
    localparam int PROG_TIME_US = 10;
    localparam int ERASE_TIME_US = 9500;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        FS_READ = 3'b000,
        FS_PROG_ARM = 3'b001,
        FS_PROG_RUN = 3'b011,
        FS_ERASE_ARM = 3'b010,
        FS_ERASE_RUN = 3'b110,
        FS_PVERIFY = 3'b111,
        FS_EVERIFY = 3'b101,
        FS_CANCEL1 = 3'b100
    } fcrs_state_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [FADDR_W-1:0] addr;
        logic [7:0] wdata;
    } fcrs_cpu_req_t;

    typedef struct packed {
        logic req;
        logic write;
        logic erase;
        logic [1:0] area;
        logic [FADDR_W-1:0] addr;
        logic [7:0] wdata;
    } fcrs_arr_req_t;
endpackage

// >>> src/fcrs_sequencer.sv
// flash cpu reprogramming sequencer with apb register slave
//
// Contract
// - mode is valid only with select bit 0 set and high voltage present
// - control bit 2 is a read-only monitor showing the mode is in effect
// - control bit 1 is read-only busy, one while erase or program runs
// - bits 4-5 pick the area; erase hits it only, programming only inside it
// - with mode valid, reads outside the selected area return no contents
// - command 00h selects read mode, which persists until another command
// - read mode after reset and after the cancel command
// - command 40h arms program; next byte write to flash programs it
// - busy rises when programming starts and falls when it ends
// - watchdog held stopped at FFFFh during program and erase
// - command C0h enters program verify; reads return stored value
// - two consecutive 20h writes start erase of the selected area; the code ignores codes other than FFh between the two, so they need not be consecutive
// - busy set while erase runs, cleared at completion
// - command A0h enters erase verify; erased locations read FFh
// - two FFh writes after 40h or 20h cancel, memory untouched
//
// The APB interface to the registers and the register offsets were decided locally.
module fcrs_sequencer import fcrs_pkg::*; #(
    parameter int PROG_CNT = PROG_CYCLES,
    parameter int ERASE_CNT = ERASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic highProgramVoltage,
    input wire fcrs_cpu_req_t cpuReq,
    output logic [7:0] cpuRdata,
    output logic cpuRvalid,
    output fcrs_arr_req_t arrReq,
    input wire logic [7:0] arrRdata,
    output logic wdtFreeze,
    output logic [15:0] wdtLoad
);
    // ==========================================================
    // registers and state
    logic [7:0] ctl_q;
    fcrs_state_t state_q;
    logic [23:0] timer_q;
    logic modeValid;
    logic busy;
    logic [1:0] area;
    logic apbAccess;
    logic cmdWrite;
    logic [7:0] cmdByte;
    logic inArea;
    logic flashRd;
    logic cancelHit;
    logic progStart;
    logic eraseStart;
    logic cmdDecode;

    assign modeValid = ctl_q[CTL_SEL_BIT] & highProgramVoltage;
    assign busy = (state_q == FS_PROG_RUN) || (state_q == FS_ERASE_RUN);
    assign area = ctl_q[CTL_AREA_LO +: 2];
    assign apbAccess = psel & penable;
    assign cmdWrite = apbAccess & pwrite & (paddr == ADDR_COMMAND) & modeValid;
    assign cmdByte = pwdata[7:0];
    assign inArea = (cpuReq.addr[AREA_HI -: 2] == area);
    assign flashRd = cpuReq.req & ~cpuReq.write;
    assign cancelHit = cmdWrite & pready & (cmdByte == CMD_RESET);
    // cancel and cpu write in one cycle: the cancel wins, so nothing reaches the array
    assign progStart = (state_q == FS_PROG_ARM) & modeValid & cpuReq.req & cpuReq.write & inArea & ~cancelHit;
    assign eraseStart = (state_q == FS_ERASE_ARM) & cmdWrite & pready & (cmdByte == CMD_ERASE);
    assign cmdDecode = cmdWrite & pready & ((state_q == FS_READ) | (state_q == FS_PVERIFY) | (state_q == FS_EVERIFY));

    // ==========================================================
    // apb slave: zero wait state, pready registered from the setup cycle, high in the first access cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel & ~penable) begin
                if (paddr == ADDR_CONTROL) begin
                    // bits 1 and 2 reflect live state, not stored bits
                    prdata <= {24'h00_0000, ctl_q[7:3], modeValid, busy, ctl_q[0]};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {29'h0000_0000, state_q};
                end else if (paddr != ADDR_COMMAND) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // only select and area bits are writable; write lands on the access edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= CTL_RESET;
        end else if (apbAccess & pready & pwrite & (paddr == ADDR_CONTROL)) begin
            ctl_q <= pwdata[7:0] & CTL_WR_MASK;
        end
    end

    // ==========================================================
    // command sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= FS_READ;
            timer_q <= 24'h00_0000;
        end else if (~modeValid) begin
            state_q <= FS_READ;
            timer_q <= 24'h00_0000;
        end else begin
            case (state_q)
                FS_PROG_RUN, FS_ERASE_RUN: begin
                    // commands during a running operation are ignored
                    if (timer_q == 24'h00_0001) begin
                        state_q <= FS_READ;
                    end
                    timer_q <= timer_q - 24'h00_0001;
                end
                FS_PROG_ARM: begin
                    if (cancelHit) begin
                        state_q <= FS_CANCEL1;
                    end else if (progStart) begin
                        state_q <= FS_PROG_RUN;
                        timer_q <= 24'(PROG_CNT);
                    end
                end
                FS_ERASE_ARM: begin
                    if (cmdWrite & pready) begin
                        if (cmdByte == CMD_ERASE) begin
                            state_q <= FS_ERASE_RUN;
                            timer_q <= 24'(ERASE_CNT);
                        end else if (cmdByte == CMD_RESET) begin
                            state_q <= FS_CANCEL1;
                        end
                    end
                end
                FS_CANCEL1: begin
                    if (cmdWrite & pready) begin
                        // second FFh completes the cancel; anything else stays pending
                        if (cmdByte == CMD_RESET) begin
                            state_q <= FS_READ;
                        end
                    end
                end
                default: begin
                    if (cmdWrite & pready) begin
                        if (cmdByte == CMD_READ) begin
                            state_q <= FS_READ;
                        end else if (cmdByte == CMD_PROGRAM) begin
                            state_q <= FS_PROG_ARM;
                        end else if (cmdByte == CMD_PVERIFY) begin
                            state_q <= FS_PVERIFY;
                        end else if (cmdByte == CMD_ERASE) begin
                            state_q <= FS_ERASE_ARM;
                        end else if (cmdByte == CMD_EVERIFY) begin
                            state_q <= FS_EVERIFY;
                        end
                        // other codes fall through unchanged
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // array port
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arrReq <= '0;
        end else begin
            arrReq <= '0;
            arrReq.area <= area;
            if (progStart) begin
                arrReq.req <= 1'b1;
                arrReq.write <= 1'b1;
                arrReq.addr <= cpuReq.addr;
                arrReq.wdata <= cpuReq.wdata;
            end else if (eraseStart) begin
                arrReq.req <= 1'b1;
                arrReq.erase <= 1'b1;
            end else if (flashRd) begin
                arrReq.req <= 1'b1;
                arrReq.addr <= cpuReq.addr;
            end
        end
    end

    // ==========================================================
    // cpu read path
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cpuRdata <= 8'h00;
            cpuRvalid <= 1'b0;
        end else begin
            cpuRvalid <= flashRd;
            // arrRdata is the raw stored byte in every read-type mode
            cpuRdata <= (modeValid && !inArea) ? 8'h00 : arrRdata;
        end
    end

    // ==========================================================
    // watchdog hold, one cycle behind busy since both sides are registered
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wdtFreeze <= 1'b0;
            wdtLoad <= 16'h0000;
        end else begin
            wdtFreeze <= busy;
            wdtLoad <= busy ? WDT_FROZEN : 16'h0000;
        end
    end

    // ==========================================================
    // checks
    AST_BUSY_PROG: assert property (@(posedge sys_clk) disable iff (rst)
        progStart |=> busy)
        else $error("program start did not raise busy");

    AST_BUSY_ERASE: assert property (@(posedge sys_clk) disable iff (rst)
        eraseStart |=> state_q == FS_ERASE_RUN)
        else $error("second erase code did not start erase");

    AST_WDT: assert property (@(posedge sys_clk) disable iff (rst)
        busy |=> (wdtFreeze && wdtLoad == WDT_FROZEN))
        else $error("watchdog not held during operation");

    AST_OUT_AREA: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == FS_PROG_ARM && cpuReq.req && cpuReq.write && !inArea) |=> !arrReq.write)
        else $error("program outside selected area");

    AST_MODE: assert property (@(posedge sys_clk) disable iff (rst)
        !highProgramVoltage |=> state_q == FS_READ)
        else $error("sequencer active without high voltage");

    AST_RDMASK: assert property (@(posedge sys_clk) disable iff (rst)
        (flashRd && modeValid && !inArea) |=> (cpuRdata == 8'h00 && cpuRvalid))
        else $error("read outside area returned contents");

    AST_CANCEL: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == FS_CANCEL1 && cmdWrite && pready && cmdByte == CMD_RESET) |=> (state_q == FS_READ && !arrReq.req))
        else $error("cancel did not return to read mode");

    AST_UNDEF: assert property (@(posedge sys_clk) disable iff (rst)
        (cmdDecode && cmdByte != CMD_READ && cmdByte != CMD_PROGRAM && cmdByte != CMD_PVERIFY
            && cmdByte != CMD_ERASE && cmdByte != CMD_EVERIFY) |=> ($stable(state_q) && !arrReq.write && !arrReq.erase))
        else $error("undefined code changed mode");

    AST_MON_RD: assert property (@(posedge sys_clk) disable iff (rst)
        (psel && !penable && paddr == ADDR_CONTROL) |=> prdata[CTL_MON_BIT] == $past(modeValid))
        else $error("monitor bit does not follow mode");

    AST_BUSY_RD: assert property (@(posedge sys_clk) disable iff (rst)
        (psel && !penable && paddr == ADDR_CONTROL) |=> prdata[CTL_BUSY_BIT] == $past(busy))
        else $error("busy bit does not follow operation");

    AST_BUSY_END: assert property (@(posedge sys_clk) disable iff (rst)
        (busy && timer_q == 24'h00_0001) |=> !busy)
        else $error("busy stayed high after operation time");

    AST_PROG_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
        progStart |=> (arrReq.req && arrReq.write && arrReq.addr == $past(cpuReq.addr)
            && arrReq.wdata == $past(cpuReq.wdata)))
        else $error("program pulse lost address or data");

    AST_ERASE_AREA: assert property (@(posedge sys_clk) disable iff (rst)
        eraseStart |=> (arrReq.req && arrReq.erase && !arrReq.write && arrReq.area == $past(area)))
        else $error("erase pulse does not carry selected area");

    AST_ARR_GATE: assert property (@(posedge sys_clk) disable iff (rst)
        (arrReq.write || arrReq.erase) |-> ($past(state_q) == FS_PROG_ARM || $past(state_q) == FS_ERASE_ARM))
        else $error("array changed without an armed command");

    AST_CANCEL_WINS: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == FS_PROG_ARM && cancelHit) |=> (!arrReq.write && state_q == FS_CANCEL1))
        else $error("cancel did not stop program");

    AST_READ_CMD: assert property (@(posedge sys_clk) disable iff (rst)
        (cmdDecode && cmdByte == CMD_READ) |=> state_q == FS_READ)
        else $error("read code did not select read mode");

    AST_PROG_CMD: assert property (@(posedge sys_clk) disable iff (rst)
        (cmdDecode && cmdByte == CMD_PROGRAM) |=> state_q == FS_PROG_ARM)
        else $error("program code did not arm program");

    AST_PVERIFY_CMD: assert property (@(posedge sys_clk) disable iff (rst)
        (cmdDecode && cmdByte == CMD_PVERIFY) |=> state_q == FS_PVERIFY)
        else $error("verify code did not select program verify");

    AST_EVERIFY_CMD: assert property (@(posedge sys_clk) disable iff (rst)
        (cmdDecode && cmdByte == CMD_EVERIFY) |=> state_q == FS_EVERIFY)
        else $error("erase verify code did not select erase verify");

    AST_RVALID: assert property (@(posedge sys_clk) disable iff (rst)
        flashRd |=> cpuRvalid)
        else $error("flash read gave no valid strobe");

    AST_VERIFY_DATA: assert property (@(posedge sys_clk) disable iff (rst)
        (flashRd && (!modeValid || inArea)) |=> cpuRdata == $past(arrRdata))
        else $error("flash read did not return stored byte");
endmodule

// >>> dv/fcrs_flash_model.sv
// flash array model that sits behind the sequencer
module fcrs_flash_model import fcrs_pkg::*; (
    input wire logic sys_clk,
    input wire logic [15:0] rdAddr,
    input wire fcrs_arr_req_t arrReq,
    output logic [7:0] arrRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    assign arrRdata = mem[rdAddr];
    // ==========
    // array update
    // programming only clears bits, as real cells do
    always @(posedge sys_clk) begin
        if (arrReq.req && arrReq.write) begin
            mem[arrReq.addr] <= mem[arrReq.addr] & arrReq.wdata;
        end
        if (arrReq.req && arrReq.erase) begin
            foreach (mem[i]) if (i[15:14] == arrReq.area) mem[i] <= 8'hFF;
        end
    end
endmodule

// >>> dv/fcrs_sequencer_tb_top.sv
// testbench for the flash reprogramming sequencer
module fcrs_sequencer_tb_top import fcrs_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pready, pslverr, slvErr, cpuRvalid, wdtFreeze, highProgramVoltage = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] cpuRdata, arrRdata;
    logic [15:0] wdtLoad;
    fcrs_cpu_req_t cpuReq = '0;
    fcrs_arr_req_t arrReq;
    int nMismatch = 0, testsRun = 0, cycles = 0;
    always #4 sys_clk = ~sys_clk;
    // short counts keep the erase wait small
    fcrs_sequencer #(.PROG_CNT(4), .ERASE_CNT(8)) dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .highProgramVoltage(highProgramVoltage), .cpuReq(cpuReq),
        .cpuRdata(cpuRdata), .cpuRvalid(cpuRvalid), .arrReq(arrReq), .arrRdata(arrRdata),
        .wdtFreeze(wdtFreeze), .wdtLoad(wdtLoad));
    fcrs_flash_model array_u (.sys_clk(sys_clk), .rdAddr(cpuReq.addr), .arrReq(arrReq), .arrRdata(arrRdata));
    // ==========
    // access tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        slvErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 8'h00);
        check(name, exp, rd);
    endtask
    task automatic flash(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpuReq <= '{1'h1, wr, a, d};
        @(posedge sys_clk);
        cpuReq.req <= 1'h0;
        @(posedge sys_clk);
        rd = {24'h0, cpuRdata};
        if (!wr) check("cpuRvalid", 32'h1, {31'h0, cpuRvalid});
    endtask
    task automatic wait_idle();
        int n = 0;
        do begin
            apb(1'h0, ADDR_CONTROL, 8'h00);
            n++;
        end while (rd[CTL_BUSY_BIT] !== 1'h0 && n < 30);
        check("busy", 32'h0, {31'h0, rd[CTL_BUSY_BIT]});
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            nMismatch++;
            complete_run();
        end
    end
    // ==========
    // tests
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        rdchk("control", ADDR_CONTROL, 32'h00);
        apb(1'h0, 12'h00C, 8'h00);
        check("pslverr", 32'h1, {31'h0, slvErr});
        apb(1'h1, ADDR_CONTROL, 8'hCD);
        rdchk("noVoltage", ADDR_CONTROL, 32'h01);
        highProgramVoltage <= 1'h1;
        apb(1'h1, ADDR_CONTROL, 8'h11);
        rdchk("monitor", ADDR_CONTROL, 32'h15);
        flash(1'h0, 16'h0010, 8'h00);
        check("outOfArea", 32'h00, rd);
        flash(1'h0, 16'h4010, 8'h00);
        check("readMode", 32'hFF, rd);
        $display("test entry done");
        apb(1'h1, ADDR_COMMAND, CMD_PROGRAM);
        flash(1'h1, 16'h4010, 8'h5A);
        rdchk("busySet", ADDR_CONTROL, 32'h17);
        wait_idle();
        apb(1'h1, ADDR_COMMAND, CMD_PVERIFY);
        flash(1'h0, 16'h4010, 8'h00);
        check("verify", 32'h5A, rd);
        apb(1'h1, ADDR_COMMAND, 8'h55);
        rdchk("undefined", ADDR_STATUS, {29'h0, FS_PVERIFY});
        apb(1'h1, ADDR_COMMAND, CMD_READ);
        rdchk("readCmd", ADDR_STATUS, {29'h0, FS_READ});
        apb(1'h1, ADDR_COMMAND, CMD_PROGRAM);
        flash(1'h1, 16'h8020, 8'h00);
        rdchk("refused", ADDR_CONTROL, 32'h15);
        apb(1'h1, ADDR_COMMAND, CMD_RESET);
        apb(1'h1, ADDR_COMMAND, CMD_RESET);
        rdchk("cancel", ADDR_STATUS, {29'h0, FS_READ});
        $display("test program done");
        // only the used byte is cleared; the whole area would overrun the cycle budget
        apb(1'h1, ADDR_COMMAND, CMD_PROGRAM);
        flash(1'h1, 16'h4010, 8'h00);
        wait_idle();
        apb(1'h1, ADDR_COMMAND, CMD_ERASE);
        apb(1'h1, ADDR_COMMAND, CMD_RESET);
        apb(1'h1, ADDR_COMMAND, CMD_RESET);
        apb(1'h1, ADDR_COMMAND, CMD_PVERIFY);
        flash(1'h0, 16'h4010, 8'h00);
        check("cancelKeeps", 32'h00, rd);
        apb(1'h1, ADDR_COMMAND, CMD_ERASE);
        apb(1'h1, ADDR_COMMAND, CMD_ERASE);
        repeat (3) @(posedge sys_clk);
        #1;
        check("wdtFreeze", 32'h1, {31'h0, wdtFreeze});
        check("wdtLoad", {16'h0, WDT_FROZEN}, {16'h0, wdtLoad});
        rdchk("eraseBusy", ADDR_CONTROL, 32'h17);
        wait_idle();
        apb(1'h1, ADDR_COMMAND, CMD_EVERIFY);
        flash(1'h0, 16'h4010, 8'h00);
        check("erased", {24'h0, ERASED_BYTE}, rd);
        $display("test erase done");
        highProgramVoltage <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rdchk("modeDrop", ADDR_CONTROL, 32'h11);
        apb(1'h1, ADDR_CONTROL, 8'h00);
        $display("test exit done");
        apb(1'h1, ADDR_CONTROL, 8'h21);
        highProgramVoltage <= 1'h1;
        apb(1'h1, ADDR_COMMAND, CMD_EVERIFY);
        rdchk("evMode", ADDR_STATUS, {29'h0, FS_EVERIFY});
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'h0;
        rdchk("resetState", ADDR_STATUS, {29'h0, FS_READ});
        rdchk("resetCtl", ADDR_CONTROL, 32'h00);
        $display("test reset done");
        complete_run();
    end
endmodule
